// >>> hw/status_pkg.sv
package status_pkg;
    // ==========================================
    // summary status byte bit positions
    localparam int STB_ALARM_BIT = 1;
    localparam int STB_QUAL_BIT = 3;
    localparam int STB_MSG_BIT = 4;
    localparam int STB_STD_BIT = 5;
    localparam int STB_RQS_BIT = 6;
    localparam int STB_OPER_BIT = 7;
    // ==========================================
    // measurement quality bit positions
    localparam int QUAL_VOLT_BIT = 0;
    localparam int QUAL_CURR_BIT = 1;
    localparam int QUAL_RES_BIT = 9;
    localparam int QUAL_TEMP_BIT = 10;
    localparam int QUAL_TOTAL_BIT = 11;
    localparam int QUAL_MEMFULL_BIT = 12;
    localparam logic [15:0] QUAL_USED = 16'h1e03;
    localparam logic [15:0] QUAL_OVLD = 16'h0603;
    // ==========================================
    // standard event bit positions
    localparam int STD_OPC_BIT = 0;
    localparam int STD_QUERY_BIT = 2;
    localparam int STD_DEV_BIT = 3;
    localparam int STD_EXEC_BIT = 4;
    localparam int STD_CMD_BIT = 5;
    localparam int STD_PWR_BIT = 7;
    localparam logic [15:0] STD_USED = 16'h00bd;
    localparam logic [15:0] ALARM_USED = 16'h003f;
    localparam logic [15:0] OPER_USED = 16'hfffe;
    // ==========================================
    // reset values
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        GRP_ALARM = 2'b00,
        GRP_QUAL = 2'b01,
        GRP_STD = 2'b10,
        GRP_OPER = 2'b11
    } group_t;

    typedef enum logic [1:0] {
        RD_COND = 2'b00,
        RD_EVENT = 2'b01,
        RD_ENABLE = 2'b10
    } read_kind_t;

    typedef enum logic {
        SQ_IDLE = 1'b0,
        SQ_WAIT = 1'b1
    } seq_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } reply_t;

    typedef struct packed {
        logic power_on;
        logic command;
        logic execution;
        logic device;
        logic query;
    } std_err_t;
endpackage

// >>> hw/event_group.sv
`timescale 1ns/1ps
`default_nettype none
module event_group #(
    parameter int W = 16,
    parameter logic [15:0] USED = 16'hffff
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // live condition and controls
    input wire logic [W-1:0] cond_in,
    input wire logic clear_evt,
    input wire logic mask_wr,
    input wire logic [W-1:0] mask_data,
    input wire logic mask_clr,
    input wire logic rst_mask_clr,
    // state out
    output logic [W-1:0] cond_out,
    output logic [W-1:0] event_out,
    output logic [W-1:0] enable_out,
    output logic [W-1:0] rise_out,
    output logic summary
);
    import status_pkg::*;

    if (W < 1 || W > 16) begin : g_bad_width
        $error("event_group width out of range");
    end

    logic [W-1:0] used_w;
    logic [W-1:0] prev_q;
    logic [W-1:0] evt_q;
    logic [W-1:0] evt_d;
    logic [W-1:0] en_q;
    logic [W-1:0] en_d;

    // ==========================================
    // condition, event, enable
    assign used_w = USED[W-1:0];
    assign cond_out = cond_in & used_w;
    assign rise_out = cond_in & ~prev_q & used_w;
    assign evt_d = (evt_q & ~{W{clear_evt}}) | rise_out;
    assign en_d = mask_clr ? MASK_RST[W-1:0] : (mask_wr ? (mask_data & used_w) : en_q);
    assign event_out = evt_q;
    assign enable_out = en_q;
    assign summary = |(evt_q & en_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= MASK_RST[W-1:0];
            evt_q <= MASK_RST[W-1:0];
        end else begin
            prev_q <= cond_in;
            evt_q <= evt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= rst_mask_clr ? MASK_RST[W-1:0] : en_q;
        end else begin
            en_q <= en_d;
        end
    end

    // ==========================================
    // checks
    a_event_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (evt_q[0] && !clear_evt) |=> evt_q[0])
        else $error("event bit dropped");
    a_event_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        (clear_evt && !rise_out[0]) |=> !evt_q[0])
        else $error("event bit not cleared");
    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (clear_evt && rise_out[0]) |=> evt_q[0])
        else $error("clear beat set");
    a_preset_mask: assert property (@(posedge clk) disable iff (sys_rst)
        mask_clr |=> (en_q == '0))
        else $error("mask not cleared");
endmodule
`default_nettype wire

// >>> hw/status_reporting_srq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module status_reporting_srq_unit (
    // clock and power-on reset
    input wire logic clk,
    input wire logic sys_rst,
    // retained setting
    input wire logic power_on_clear_setting,
    // instrument state
    input wire logic [15:0] alarm_cond,
    input wire logic [15:0] oper_cond,
    input wire logic [4:0] overload_cond,
    input wire logic storage_full,
    input wire logic readings_lost,
    input wire status_pkg::std_err_t std_err,
    input wire logic output_buffer_has_data,
    input wire logic commands_busy,
    input wire logic scan_running,
    // command strobes
    input wire logic clear_all_status_cmd,
    input wire logic mask_preset_cmd,
    input wire logic completion_mark_cmd,
    input wire logic mask_write_cmd,
    input wire status_pkg::group_t mask_grp,
    input wire logic [15:0] mask_data,
    input wire logic summary_mask_write_cmd,
    input wire logic [7:0] summary_mask_data,
    input wire logic read_cmd,
    input wire status_pkg::group_t read_grp,
    input wire status_pkg::read_kind_t read_kind,
    input wire logic summary_read_query,
    input wire logic serial_poll,
    // answers
    output status_pkg::reply_t read_reply,
    output status_pkg::reply_t summary_reply,
    output status_pkg::reply_t poll_reply,
    output logic [7:0] summary_mask,
    output logic srq
);
    import status_pkg::*;

    logic [15:0] cond_w [4];
    logic [15:0] evt_w [4];
    logic [15:0] en_w [4];
    logic [15:0] rise_w [4];
    logic [15:0] used_w [4];
    logic [3:0] sum_w;
    logic [3:0] evt_clr_w;
    logic [3:0] mask_wr_w;
    logic [15:0] qual_cond_w;
    logic [15:0] std_cond_w;
    logic [15:0] read_word_w;
    logic [7:0] stb_base_w;
    logic [7:0] stb_poll_w;
    logic [7:0] stb_query_w;
    logic master_w;
    logic rqs_set_w;
    logic opc_done_w;
    logic sq_go_w;
    logic overload_w;
    logic pon_q;
    logic master_q;
    logic rqs_q;
    logic rqs_d;
    logic opc_pend_q;
    logic [7:0] sre_q;
    logic [7:0] sre_d;
    seq_state_t sq_q;
    seq_state_t sq_d;
    reply_t read_q;
    reply_t sum_q;
    reply_t poll_q;

    // ==========================================
    // condition sources
    assign qual_cond_w = {3'b000, storage_full & readings_lost,
        overload_cond[4:2], 7'h00, overload_cond[1:0]};
    assign overload_w = |(rise_w[GRP_QUAL] & QUAL_OVLD);
    assign opc_done_w = opc_pend_q && !commands_busy && !scan_running;
    assign std_cond_w = {8'h00, pon_q, 1'b0, std_err.command, std_err.execution,
        std_err.device | overload_w, std_err.query, 1'b0, opc_done_w};
    assign cond_w[GRP_ALARM] = alarm_cond;
    assign cond_w[GRP_QUAL] = qual_cond_w;
    assign cond_w[GRP_STD] = std_cond_w;
    assign cond_w[GRP_OPER] = oper_cond;
    assign used_w[GRP_ALARM] = ALARM_USED;
    assign used_w[GRP_QUAL] = QUAL_USED;
    assign used_w[GRP_STD] = STD_USED;
    assign used_w[GRP_OPER] = OPER_USED;

    // ==========================================
    // register groups
    for (genvar g = 0; g < 4; g++) begin : g_grp
        assign evt_clr_w[g] = clear_all_status_cmd
            || (read_cmd && read_kind == RD_EVENT && read_grp == group_t'(g));
        assign mask_wr_w[g] = mask_write_cmd && mask_grp == group_t'(g);
        event_group #(.W(16), .USED(used_w_init(g))) u_grp (
            .clk(clk),
            .sys_rst(sys_rst),
            .cond_in(cond_w[g]),
            .clear_evt(evt_clr_w[g]),
            .mask_wr(mask_wr_w[g]),
            .mask_data(mask_data),
            .mask_clr(mask_preset_cmd),
            .rst_mask_clr(g == GRP_STD ? power_on_clear_setting : 1'b1),
            .cond_out(),
            .event_out(evt_w[g]),
            .enable_out(en_w[g]),
            .rise_out(rise_w[g]),
            .summary(sum_w[g])
        );
    end

    function automatic logic [15:0] used_w_init(input int g);
        case (g)
            0: used_w_init = ALARM_USED;
            1: used_w_init = QUAL_USED;
            2: used_w_init = STD_USED;
            default: used_w_init = OPER_USED;
        endcase
    endfunction

    // ==========================================
    // summary status byte
    assign stb_base_w = {sum_w[GRP_OPER], 1'b0, sum_w[GRP_STD], output_buffer_has_data,
        sum_w[GRP_QUAL], 1'b0, sum_w[GRP_ALARM], 1'b0};
    assign master_w = |(stb_base_w & sre_q);
    assign stb_poll_w = stb_base_w | (8'(rqs_q) << STB_RQS_BIT);
    assign stb_query_w = stb_base_w | (8'(master_w) << STB_RQS_BIT);
    assign rqs_set_w = master_w && !master_q;
    assign rqs_d = rqs_set_w || (rqs_q && !serial_poll);
    assign sre_d = summary_mask_write_cmd ? summary_mask_data : sre_q;
    assign srq = rqs_q;
    assign summary_mask = sre_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sre_q <= power_on_clear_setting ? SRE_RST : sre_q;
        end else begin
            sre_q <= sre_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pon_q <= 1'b1;
            master_q <= 1'b0;
            rqs_q <= 1'b0;
            opc_pend_q <= 1'b0;
        end else begin
            pon_q <= 1'b0;
            master_q <= master_w;
            rqs_q <= rqs_d;
            opc_pend_q <= completion_mark_cmd || (opc_pend_q && !opc_done_w);
        end
    end

    // ==========================================
    // in-order summary query
    assign sq_go_w = (sq_q == SQ_WAIT) && !commands_busy;

    always_comb begin
        sq_d = sq_q;
        unique case (sq_q)
            SQ_IDLE: begin
                if (summary_read_query) begin
                    sq_d = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (sq_go_w) begin
                    sq_d = SQ_IDLE;
                end
            end
        endcase
    end

    // ==========================================
    // answers
    assign read_word_w = read_kind == RD_COND ? cond_w[read_grp] & used_w[read_grp]
        : (read_kind == RD_EVENT ? evt_w[read_grp] : en_w[read_grp]);
    assign read_reply = read_q;
    assign summary_reply = sum_q;
    assign poll_reply = poll_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sq_q <= SQ_IDLE;
            read_q <= '0;
            sum_q <= '0;
            poll_q <= '0;
        end else begin
            sq_q <= sq_d;
            read_q <= '{valid: read_cmd, data: read_cmd ? read_word_w : WORD_RST};
            sum_q <= '{valid: sq_go_w, data: {8'h00, stb_query_w}};
            poll_q <= '{valid: serial_poll, data: {8'h00, stb_poll_w}};
        end
    end

    // ==========================================
    // checks
    a_srq_on_rise: assert property (@(posedge clk) disable iff (sys_rst)
        rqs_set_w |=> srq)
        else $error("request not raised");
    a_srq_needs_rise: assert property (@(posedge clk) disable iff (sys_rst)
        (!rqs_set_w && !srq) |=> !srq)
        else $error("request without rise");
    a_poll_releases: assert property (@(posedge clk) disable iff (sys_rst)
        (serial_poll && !rqs_set_w) |=> !srq)
        else $error("poll kept request");
    a_poll_others_kept: assert property (@(posedge clk) disable iff (sys_rst)
        serial_poll |=> (poll_reply.data[7:0] & 8'hbf) == $past(stb_base_w))
        else $error("poll answer bits wrong");
    a_poll_answer: assert property (@(posedge clk) disable iff (sys_rst)
        serial_poll |=> (poll_reply.valid && poll_reply.data[STB_RQS_BIT] == $past(rqs_q)))
        else $error("poll answer wrong");
    a_poll_reply_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !serial_poll |=> !poll_reply.valid)
        else $error("poll answer unasked");
    a_query_value: assert property (@(posedge clk) disable iff (sys_rst)
        sq_go_w |=> summary_reply.data[STB_RQS_BIT] == |($past(stb_base_w) & $past(sre_q)))
        else $error("query summary bit wrong");
    a_query_keeps_srq: assert property (@(posedge clk) disable iff (sys_rst)
        (srq && !serial_poll) |=> srq)
        else $error("request dropped");
    a_query_waits: assert property (@(posedge clk) disable iff (sys_rst)
        (sq_q == SQ_WAIT && commands_busy) |=> !summary_reply.valid)
        else $error("query ran early");
    a_query_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (sq_q == SQ_IDLE) |=> !summary_reply.valid)
        else $error("query answer unasked");
    a_read_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        read_cmd |=> read_reply.valid)
        else $error("read not answered");
    a_read_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !read_cmd |=> (!read_reply.valid && read_reply.data == WORD_RST))
        else $error("read answer unasked");
    a_query_clears_qual: assert property (@(posedge clk) disable iff (sys_rst)
        (evt_clr_w[GRP_QUAL] && rise_w[GRP_QUAL] == WORD_RST) |=> evt_w[GRP_QUAL] == WORD_RST)
        else $error("quality events not cleared");
    a_clear_keeps_mask: assert property (@(posedge clk) disable iff (sys_rst)
        (clear_all_status_cmd && !mask_write_cmd && !mask_preset_cmd)
        |=> en_w[GRP_QUAL] == $past(en_w[GRP_QUAL]))
        else $error("clear all changed mask");
    a_clear_all_std: assert property (@(posedge clk) disable iff (sys_rst)
        (clear_all_status_cmd && rise_w[GRP_STD] == WORD_RST) |=> evt_w[GRP_STD] == WORD_RST)
        else $error("clear all left events");
    a_msg_flag: assert property (@(posedge clk) disable iff (sys_rst)
        stb_poll_w[STB_MSG_BIT] == output_buffer_has_data)
        else $error("message flag wrong");
    a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !stb_poll_w[0] && !stb_poll_w[2] && (evt_w[GRP_QUAL] & ~QUAL_USED) == '0)
        else $error("unused bit set");
    a_qual_summary: assert property (@(posedge clk) disable iff (sys_rst)
        stb_base_w[STB_QUAL_BIT] == |(evt_w[GRP_QUAL] & en_w[GRP_QUAL]))
        else $error("quality summary wrong");
    a_alarm_summary: assert property (@(posedge clk) disable iff (sys_rst)
        stb_base_w[STB_ALARM_BIT] == |(evt_w[GRP_ALARM] & en_w[GRP_ALARM]))
        else $error("alarm summary wrong");
    a_sre_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (summary_mask_write_cmd && summary_mask_data == SRE_RST) |=> summary_mask == SRE_RST)
        else $error("summary mask not cleared");
    a_qual_mask_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (mask_write_cmd && mask_grp == GRP_QUAL && mask_data == MASK_RST && !mask_preset_cmd)
        |=> en_w[GRP_QUAL] == MASK_RST)
        else $error("quality mask not cleared");
    a_memfull_event: assert property (@(posedge clk) disable iff (sys_rst)
        rise_w[GRP_QUAL][QUAL_MEMFULL_BIT] |=> evt_w[GRP_QUAL][QUAL_MEMFULL_BIT])
        else $error("memory full not latched");
    a_opc_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (opc_done_w && !evt_clr_w[GRP_STD]) |=> evt_w[GRP_STD][STD_OPC_BIT])
        else $error("completion not latched");
    a_opc_waits: assert property (@(posedge clk) disable iff (sys_rst)
        (opc_pend_q && scan_running) |=> !rise_w[GRP_STD][STD_OPC_BIT] || !scan_running)
        else $error("completion during scan");
    a_overload_std: assert property (@(posedge clk) disable iff (sys_rst)
        (overload_w && !clear_all_status_cmd) |=> evt_w[GRP_STD][STD_DEV_BIT])
        else $error("overload not reported");
endmodule
`default_nettype wire

// >>> verification/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus controller: serial poll after a service request
module host_ctrl_model (
    // clock
    input wire logic clk,
    // device side
    input wire logic srq,
    input wire status_pkg::reply_t poll_reply,
    // bench side
    input wire logic [3:0] poll_delay,
    output logic serial_poll,
    output logic [7:0] poll_byte,
    output var int polls
);
    import status_pkg::*;
    int cnt;
    logic fire;
    initial begin
        serial_poll = 1'b0;
        poll_byte = 8'h00;
        polls = 0;
        cnt = 0;
    end
    always @(negedge clk) begin
        fire = 1'b0;
        if (srq !== 1'b1) begin
            cnt = 0;
        end else if (serial_poll !== 1'b1) begin
            if (cnt >= poll_delay) begin
                fire = 1'b1;
                cnt = 0;
            end else begin
                cnt = cnt + 1;
            end
        end
        serial_poll <= fire;
        if (poll_reply.valid === 1'b1) begin
            poll_byte <= poll_reply.data[7:0];
            polls <= polls + 1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_status_reporting_srq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_status_reporting_srq_unit;
    import status_pkg::*;
    logic clk, sys_rst, pocs, sfull, rlost, obuf, busy, scan;
    logic clr_all, preset, opc, mwr, smwr, rd, sq, poll, srq;
    logic [15:0] alarm_cond, oper_cond, mask_data, got, v;
    logic [4:0] ov;
    logic [7:0] sm_data, summary_mask, poll_byte;
    logic [3:0] pdly;
    group_t mask_grp, read_grp;
    read_kind_t read_kind;
    std_err_t serr;
    reply_t read_reply, summary_reply, poll_reply;
    int polls, num_errors, tests_run;
    status_reporting_srq_unit dut (.clk(clk), .sys_rst(sys_rst), .power_on_clear_setting(pocs),
        .alarm_cond(alarm_cond), .oper_cond(oper_cond), .overload_cond(ov), .storage_full(sfull),
        .readings_lost(rlost), .std_err(serr), .output_buffer_has_data(obuf),
        .commands_busy(busy), .scan_running(scan), .clear_all_status_cmd(clr_all),
        .mask_preset_cmd(preset), .completion_mark_cmd(opc), .mask_write_cmd(mwr),
        .mask_grp(mask_grp), .mask_data(mask_data), .summary_mask_write_cmd(smwr),
        .summary_mask_data(sm_data), .read_cmd(rd), .read_grp(read_grp), .read_kind(read_kind),
        .summary_read_query(sq), .serial_poll(poll), .read_reply(read_reply),
        .summary_reply(summary_reply), .poll_reply(poll_reply), .summary_mask(summary_mask),
        .srq(srq));
    host_ctrl_model host (.clk(clk), .srq(srq), .poll_reply(poll_reply), .poll_delay(pdly),
        .serial_poll(poll), .poll_byte(poll_byte), .polls(polls));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic rd_reg(input group_t g, input read_kind_t k);
        tick(1);
        rd = 1'b1;
        read_grp = g;
        read_kind = k;
        tick(1);
        rd = 1'b0;
        got = read_reply.data;
        check("read_valid", {15'h0, read_reply.valid}, 16'h0001);
    endtask
    task automatic wr_mask(input group_t g, input logic [15:0] d);
        tick(1);
        mwr = 1'b1;
        mask_grp = g;
        mask_data = d;
        tick(1);
        mwr = 1'b0;
    endtask
    task automatic wr_sum(input logic [7:0] d);
        tick(1);
        smwr = 1'b1;
        sm_data = d;
        tick(1);
        smwr = 1'b0;
    endtask
    task automatic query_stb;
        int n;
        pulse(sq);
        n = 0;
        while (summary_reply.valid !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        check("stb_valid", {15'h0, summary_reply.valid}, 16'h0001);
        got = summary_reply.data;
    endtask
    function automatic logic [15:0] exp_qual(input logic [4:0] o, input logic f, input logic l);
        return {3'h0, f & l, o[4:2], 7'h00, o[1:0]};
    endfunction
    function automatic logic [15:0] exp_stb(input logic q, input logic m, input logic [7:0] sm);
        logic [7:0] b;
        b = {3'b000, m, q, 3'b000};
        b[STB_RQS_BIT] = |(b & sm);
        return {8'h00, b};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    // ==========================================
    // main sequence
    initial begin
        {sys_rst, pocs} = 2'b11;
        serr = '0;
        {clr_all, preset, opc, mwr, smwr, rd, sq} = 7'h00;
        {sfull, rlost, obuf, busy, scan} = 5'h00;
        {alarm_cond, oper_cond, mask_data, ov, sm_data, pdly} = '0;
        mask_grp = GRP_ALARM;
        read_grp = GRP_ALARM;
        read_kind = RD_COND;
        num_errors = 0;
        tests_run = 0;
        void'($urandom(92));
        tick(20);
        sys_rst = 1'b0;
        check("sum_mask_por", {8'h00, summary_mask}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            alarm_cond = 16'($urandom);
            oper_cond = 16'($urandom);
            rd_reg(GRP_ALARM, RD_COND);
            check("alarm_cond", got, alarm_cond & ALARM_USED);
            rd_reg(GRP_ALARM, RD_COND);
            check("alarm_cond_again", got, alarm_cond & ALARM_USED);
            rd_reg(GRP_OPER, RD_COND);
            check("oper_cond", got, oper_cond & OPER_USED);
        end
        pulse(clr_all);
        for (int i = 0; i < 5; i++) begin
            ov = (i == 0) ? 5'h1f : 5'($urandom);
            sfull = 1'b1;
            rlost = 1'($urandom);
            tick(2);
            rd_reg(GRP_QUAL, RD_EVENT);
            check("qual_event", got, exp_qual(ov, sfull, rlost));
            rd_reg(GRP_QUAL, RD_EVENT);
            check("qual_event_cleared", got, 16'h0000);
            rd_reg(GRP_STD, RD_EVENT);
            check("std_dev_bit", got & 16'h0008, {12'h0, |ov[3:0], 3'h0});
            {ov, sfull} = 6'h00;
            tick(2);
        end
        v = 16'($urandom);
        wr_mask(GRP_QUAL, v);
        pulse(clr_all);
        rd_reg(GRP_QUAL, RD_ENABLE);
        check("qual_mask_kept", got, v & QUAL_USED);
        pulse(preset);
        rd_reg(GRP_QUAL, RD_ENABLE);
        check("qual_mask_preset", got, 16'h0000);
        wr_mask(GRP_QUAL, v);
        wr_mask(GRP_QUAL, 16'h0000);
        rd_reg(GRP_QUAL, RD_ENABLE);
        check("qual_mask_zero", got, 16'h0000);
        pdly = 4'hf;
        wr_mask(GRP_QUAL, 16'h0001);
        wr_sum(8'h08);
        obuf = 1'b1;
        query_stb();
        check("stb_msg", got, exp_stb(1'b0, 1'b1, 8'h08));
        ov = 5'h01;
        busy = 1'b1;
        tick(3);
        check("srq_rise", {15'h0, srq}, 16'h0001);
        pulse(sq);
        for (int i = 0; i < 4; i++) begin
            tick(1);
            check("stb_waits", {15'h0, summary_reply.valid}, 16'h0000);
        end
        busy = 1'b0;
        query_stb();
        check("stb_qual", got, exp_stb(1'b1, 1'b1, 8'h08));
        check("srq_kept", {15'h0, srq}, 16'h0001);
        tick(12);
        check("srq_released", {15'h0, srq}, 16'h0000);
        check("poll_count", 16'(polls), 16'h0001);
        check("poll_byte", {8'h00, poll_byte}, exp_stb(1'b1, 1'b1, 8'h08));
        rd_reg(GRP_QUAL, RD_EVENT);
        query_stb();
        check("stb_group_clear", got, exp_stb(1'b0, 1'b1, 8'h08));
        obuf = 1'b0;
        query_stb();
        check("stb_msg_gone", got, 16'h0000);
        ov = 5'h00;
        pulse(clr_all);
        scan = 1'b1;
        pulse(opc);
        tick(3);
        rd_reg(GRP_STD, RD_EVENT);
        check("opc_waits", got & 16'h0001, 16'h0000);
        scan = 1'b0;
        tick(2);
        rd_reg(GRP_STD, RD_EVENT);
        check("opc_done", got & 16'h0001, 16'h0001);
        tick(1);
        serr.command = 1'b1;
        tick(1);
        serr.command = 1'b0;
        wr_mask(GRP_STD, 16'h0020);
        wr_sum(8'h20);
        query_stb();
        check("stb_std", got, 16'h0060);
        rd_reg(GRP_STD, RD_EVENT);
        check("std_cmd_event", got & 16'h0020, 16'h0020);
        query_stb();
        check("stb_std_clear", got, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            sm_data = 8'($urandom);
            wr_sum(sm_data | 8'h01);
            wr_mask(GRP_QUAL, 16'h0003);
            pocs = 1'(p);
            tick(1);
            sys_rst = 1'b1;
            tick(3);
            sys_rst = 1'b0;
            check("sum_mask_psc", {8'h00, summary_mask}, p ? 16'h0000 : {8'h00, sm_data | 8'h01});
            rd_reg(GRP_QUAL, RD_ENABLE);
            check("qual_mask_por", got, 16'h0000);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
